/* File: odr_pkg.sv */
// Constants, state codes and carrier types shared by the data randomizer.
package odr_pkg;

	// Width of one data byte.
	localparam int ODR_BYTE_W = 8;
	// Index of the last bit of a byte.
	localparam logic [2:0] ODR_BIT_LAST = 3'h7;
	// Padding byte for a payload shorter than its allocation, all ones.
	localparam logic [7:0] ODR_PAD_BYTE = 8'hFF;

	// Seven-stage register: stage n sits at bit 7-n, so x7 is bit 0.
	localparam int ODR_P7_W = 7;
	// Taps for x^7 and x^4.
	localparam int ODR_P7_TAP_A = 0;
	localparam int ODR_P7_TAP_B = 3;
	// Non-zero value after reset; only receive seeding can bring the register to zero.
	localparam logic [6:0] ODR_P7_RESET = 7'h7F;
	// Zero bits that open each seven-stage transmit burst.
	localparam logic [2:0] ODR_PREFIX_BITS = 3'h7;

	// Fifteen-stage register: stage n sits at bit 15-n, MSB is stage 1.
	localparam int ODR_P15_W = 15;
	// Taps for x^14 and x^15.
	localparam int ODR_P15_TAP_A = 1;
	localparam int ODR_P15_TAP_B = 0;
	// Seed 100101010000000 with stage 1 on the left.
	localparam logic [14:0] ODR_P15_SEED = 15'h4A80;
	// Bytes after which the fifteen-stage register is seeded again.
	localparam int ODR_REINIT_BYTES = 1250;

	// Depth of the byte FIFO in front of the serializer.
	localparam int ODR_FIFO_DEPTH = 16;

	// Randomizer method selection.
	typedef enum logic {
		ODR_M7 = 1'b0,
		ODR_M15 = 1'b1
	} odr_method_t;

	// Sequencer states, Gray coded along IDLE, PREFIX, DATA, PAD.
	typedef enum logic [1:0] {
		ODR_IDLE = 2'b00,
		ODR_PREFIX = 2'b01,
		ODR_DATA = 2'b11,
		ODR_PAD = 2'b10
	} odr_state_t;

	// One byte from the MAC side with its end-of-payload mark.
	typedef struct packed {
		logic [7:0] data;
		logic last;
	} odr_byte_t;

	// One randomized bit toward the FEC encoder.
	typedef struct packed {
		logic bitVal;
		logic first;
		logic last;
	} odr_bit_t;

endpackage : odr_pkg

/* File: odr_fifo.sv */
// Parameterised flip-flop FIFO with valid and ready on both sides.
module odr_fifo #(
	parameter int W = 9,
	parameter int DEPTH = 16
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic arst_n,
	// Filling side.
	input wire logic fillValid,
	output logic fillReady,
	input wire logic [W-1:0] fillData,
	// Draining side.
	output logic drainValid,
	input wire logic drainReady,
	output logic [W-1:0] drainData
);

	// Pointer width; DEPTH must be a power of two.
	localparam int AW = $clog2(DEPTH);

	// Storage, one word per entry.
	logic [W-1:0] mem_q [DEPTH];
	// Pointers carry one extra bit to tell full from empty.
	logic [AW:0] wrPtr_q;
	logic [AW:0] rdPtr_q;
	// Decoded conditions.
	wire sameIdx = wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0];
	wire empty = sameIdx && (wrPtr_q[AW] == rdPtr_q[AW]);
	wire full = sameIdx && (wrPtr_q[AW] != rdPtr_q[AW]);
	wire push = fillValid && !full;
	wire pop = drainReady && !empty;

	// Honest flags: a full FIFO refuses, an empty one offers nothing.
	assign fillReady = !full;
	assign drainValid = !empty;
	assign drainData = mem_q[rdPtr_q[AW-1:0]];

	// Pointer update.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
		end else begin
			if (push) begin
				wrPtr_q <= wrPtr_q + 1'b1;
			end
			if (pop) begin
				rdPtr_q <= rdPtr_q + 1'b1;
			end
		end
	end

	// Storage write; contents need no reset since empty hides them.
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_q[wrPtr_q[AW-1:0]] <= fillData;
		end
	end

endmodule : odr_fifo

/* File: odr_randomizer.sv */
// Bit-serial data randomizer with two selectable whitening methods.
module odr_randomizer #(
	parameter int ALLOC_W = 16,
	parameter int FIFO_DEPTH = odr_pkg::ODR_FIFO_DEPTH
) (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic arst_n,
	// Static configuration, sampled when an allocation starts.
	input wire odr_pkg::odr_method_t cfgMethod,
	input wire logic cfgRx,
	// Allocation start with its size in bytes.
	input wire logic allocStart,
	input wire logic [ALLOC_W-1:0] allocBytes,
	output logic busy,
	// Byte stream from the MAC side.
	input wire logic byteValid,
	output logic byteReady,
	input wire odr_pkg::odr_byte_t byteData,
	// Bit stream toward the FEC encoder.
	output logic bitValid,
	input wire logic bitReady,
	output odr_pkg::odr_bit_t bitData
);
	import odr_pkg::*;

	// Checks run on the single clock and are off during reset.
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);

	// Counter width for the reseed interval.
	localparam int BLK_W = $clog2(ODR_REINIT_BYTES);
	// Last count of a reseed interval.
	localparam logic [BLK_W-1:0] BLK_LAST = BLK_W'(ODR_REINIT_BYTES - 1);
	// Last prefix bit index.
	localparam logic [2:0] PREFIX_LAST = ODR_PREFIX_BITS - 3'h1;

	// Sequencer state.
	odr_state_t state_q;
	odr_state_t state_d;
	// Method and direction captured for the whole allocation.
	odr_method_t method_q;
	logic rx_q;
	// Allocation size and bytes emitted so far.
	logic [ALLOC_W-1:0] allocBytes_q;
	logic [ALLOC_W-1:0] byteCnt_q;
	// Bytes since the last fifteen-stage seeding.
	logic [BLK_W-1:0] blkCnt_q;
	// Sequence registers of both methods.
	logic [ODR_P7_W-1:0] lfsr7_q;
	logic [ODR_P15_W-1:0] lfsr15_q;
	// Byte being serialized, its end mark and its bit index.
	logic [7:0] shByte_q;
	logic byteLast_q;
	logic byteHeld_q;
	logic [2:0] bitIdx_q;
	// Counts prefix bits on transmit and seeding bits on receive.
	logic [2:0] preCnt_q;
	// Output stage and first-bit marker.
	odr_bit_t out_q;
	logic outValid_q;
	logic firstPend_q;
	// FIFO draining side.
	logic fifoValid;
	logic fifoReady;
	odr_byte_t fifoData;

	// The FIFO absorbs MAC bursts while the serializer spends nine
	// cycles per byte; its ready is the back-pressure seen by the MAC.
	odr_fifo #(
		.W($bits(odr_byte_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.fillValid(byteValid),
		.fillReady(byteReady),
		.fillData(byteData),
		.drainValid(fifoValid),
		.drainReady(fifoReady),
		.drainData(fifoData)
	);

	// State decodes.
	wire isIdle = state_q == ODR_IDLE;
	wire isPre = state_q == ODR_PREFIX;
	wire isPad = state_q == ODR_PAD;
	wire inBytes = (state_q == ODR_DATA) || isPad;
	wire isM15 = method_q == ODR_M15;
	// A new allocation is taken only when idle.
	wire allocGo = allocStart && isIdle;
	// The output register may take a new bit.
	wire slotFree = !outValid_q || bitReady;
	// Byte loading, from the FIFO or from the pad constant.
	assign fifoReady = (state_q == ODR_DATA) && !byteHeld_q;
	wire loadFifo = fifoValid && fifoReady;
	wire loadPad = isPad && !byteHeld_q;
	// One step of the sequence per emitted bit.
	wire stepData = inBytes && byteHeld_q && slotFree;
	wire stepPre = isPre && slotFree;
	wire step = stepData || stepPre;
	// Byte bit order differs by method.
	wire [2:0] msbIdx = ODR_BIT_LAST - bitIdx_q;
	wire dataBit = isM15 ? shByte_q[msbIdx] : shByte_q[bitIdx_q];
	wire inBit = stepPre ? 1'b0 : dataBit;
	// Sequence bits.
	wire seq7 = lfsr7_q[ODR_P7_TAP_A] ^ lfsr7_q[ODR_P7_TAP_B];
	wire seq15 = lfsr15_q[ODR_P15_TAP_A] ^ lfsr15_q[ODR_P15_TAP_B];
	wire seqBit = isM15 ? seq15 : seq7;
	wire outBit = inBit ^ seqBit;
	// On seven-stage receive the first seven bits are the sender's register state,
	// because the sender scrambled zeros; feeding them in aligns ours.
	wire rxSeed = rx_q && !isM15 && (preCnt_q != ODR_PREFIX_BITS);
	wire fb7 = rxSeed ? inBit : seq7;
	// Byte boundaries.
	wire byteDone = stepData && (bitIdx_q == ODR_BIT_LAST);
	wire [ALLOC_W-1:0] byteCntNext = byteCnt_q + 1'b1;
	wire padNeed = isM15 && !rx_q && (byteCntNext < allocBytes_q);
	wire dataEnd = (state_q == ODR_DATA) && byteLast_q && !padNeed;
	wire padEnd = isPad && (byteCntNext >= allocBytes_q);
	wire endNow = byteDone && (dataEnd || padEnd);
	wire blkWrap = byteDone && isM15 && (blkCnt_q == BLK_LAST);

	// Sequencer next state.
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ODR_IDLE: begin
				if (allocGo) begin
					// Only a seven-stage transmit sends the zero prefix.
					if (cfgMethod == ODR_M7 && !cfgRx) begin
						state_d = ODR_PREFIX;
					end else begin
						state_d = ODR_DATA;
					end
				end
			end
			ODR_PREFIX: begin
				if (stepPre && preCnt_q == PREFIX_LAST) begin
					state_d = ODR_DATA;
				end
			end
			ODR_DATA: begin
				if (endNow) begin
					state_d = ODR_IDLE;
				end else if (byteDone && byteLast_q) begin
					state_d = ODR_PAD;
				end
			end
			ODR_PAD: begin
				if (endNow) begin
					state_d = ODR_IDLE;
				end
			end
		endcase
	end

	// State and per-allocation configuration.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= ODR_IDLE;
			method_q <= ODR_M7;
			rx_q <= 1'b0;
			allocBytes_q <= '0;
		end else begin
			state_q <= state_d;
			// Configuration is frozen for the allocation.
			if (allocGo) begin
				method_q <= cfgMethod;
				rx_q <= cfgRx;
				allocBytes_q <= allocBytes;
			end
		end
	end

	// Seven-stage register; it free-runs while idle so that each burst
	// starts from a non-zero state that moves on with every idle cycle.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			lfsr7_q <= ODR_P7_RESET;
		end else if (isIdle) begin
			lfsr7_q <= {seq7, lfsr7_q[ODR_P7_W-1:1]};
		end else if (step && !isM15) begin
			lfsr7_q <= {fb7, lfsr7_q[ODR_P7_W-1:1]};
		end
	end

	// Fifteen-stage register; reseeding beats shifting on a wrap byte.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			lfsr15_q <= ODR_P15_SEED;
		end else if (allocGo || blkWrap) begin
			lfsr15_q <= ODR_P15_SEED;
		end else if (step && isM15) begin
			lfsr15_q <= {seq15, lfsr15_q[ODR_P15_W-1:1]};
		end
	end

	// Byte counters for padding and for the reseed interval.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			byteCnt_q <= '0;
			blkCnt_q <= '0;
		end else if (allocGo) begin
			byteCnt_q <= '0;
			blkCnt_q <= '0;
		end else if (byteDone) begin
			byteCnt_q <= byteCntNext;
			blkCnt_q <= blkWrap ? '0 : blkCnt_q + 1'b1;
		end
	end

	// Prefix and receive-seeding counter; it saturates at seven.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			preCnt_q <= '0;
		end else if (allocGo) begin
			preCnt_q <= '0;
		end else if (step && preCnt_q != ODR_PREFIX_BITS) begin
			preCnt_q <= preCnt_q + 3'h1;
		end
	end

	// Byte holder and serializer position.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			shByte_q <= '0;
			byteLast_q <= 1'b0;
			byteHeld_q <= 1'b0;
			bitIdx_q <= '0;
		end else if (loadFifo) begin
			shByte_q <= fifoData.data;
			byteLast_q <= fifoData.last;
			byteHeld_q <= 1'b1;
			bitIdx_q <= '0;
		end else if (loadPad) begin
			shByte_q <= ODR_PAD_BYTE;
			byteLast_q <= 1'b1;
			byteHeld_q <= 1'b1;
			bitIdx_q <= '0;
		end else if (stepData) begin
			byteHeld_q <= !byteDone;
			bitIdx_q <= bitIdx_q + 3'h1;
		end
	end

	// Output register feeding the FEC encoder, which follows us.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			out_q <= '0;
			outValid_q <= 1'b0;
			firstPend_q <= 1'b0;
		end else begin
			if (step) begin
				out_q <= '{bitVal: outBit, first: firstPend_q, last: endNow};
				outValid_q <= 1'b1;
			end else if (bitReady) begin
				outValid_q <= 1'b0;
			end
			if (allocGo) begin
				firstPend_q <= 1'b1;
			end else if (step) begin
				firstPend_q <= 1'b0;
			end
		end
	end

	// Outputs.
	assign busy = !isIdle;
	assign bitValid = outValid_q;
	assign bitData = out_q;

	a_prefix_zero: assert property (
		stepPre |=> out_q.bitVal == $past(seq7))
		else $error("prefix bit is not the plain sequence bit");

	a_p7_feedback: assert property (
		step && !isM15 && !rxSeed && !isIdle
		|=> lfsr7_q == {$past(seq7), $past(lfsr7_q[ODR_P7_W-1:1])})
		else $error("seven-stage register stepped wrongly");

	a_p7_nonzero: assert property (
		lfsr7_q != '0)
		else $error("seven-stage register reached zero");

	a_rx_seeding: assert property (
		step && rxSeed |=> lfsr7_q[ODR_P7_W-1] == $past(inBit))
		else $error("receive seeding did not load the input bit");

	a_alloc_seed: assert property (
		allocGo |=> lfsr15_q == ODR_P15_SEED && state_q != ODR_IDLE)
		else $error("allocation did not seed the register");

	a_reseed_wrap: assert property (
		blkWrap |=> lfsr15_q == ODR_P15_SEED && blkCnt_q == '0)
		else $error("reseed after the byte interval missing");

	a_p15_feedback: assert property (
		step && isM15 && !blkWrap
		|=> lfsr15_q == {$past(seq15), $past(lfsr15_q[ODR_P15_W-1:1])})
		else $error("fifteen-stage register stepped wrongly");

	a_lsb_first: assert property (
		stepData && !isM15 && bitIdx_q == '0 && !rxSeed
		|=> out_q.bitVal == ($past(shByte_q[0]) ^ $past(seq7)))
		else $error("seven-stage byte did not start with its LSB");

	a_msb_first: assert property (
		stepData && isM15 && bitIdx_q == '0
		|=> out_q.bitVal == ($past(shByte_q[7]) ^ $past(seq15)))
		else $error("fifteen-stage byte did not start with its MSB");

	a_pad_ones: assert property (
		stepData && isPad |-> shByte_q == ODR_PAD_BYTE && isM15)
		else $error("padding byte is not all ones");

	a_method_hold: assert property (
		!isIdle && !$past(isIdle) |-> $stable(method_q))
		else $error("method changed inside an allocation");

	a_out_hold: assert property (
		bitValid && !bitReady |=> bitValid && $stable(bitData))
		else $error("stalled output bit changed");

	// Main scenarios.
	c_m7_burst: cover property (stepPre ##[1:1000] (endNow && !isM15));
	c_m15_pad: cover property (isPad && byteDone);
	c_m15_wrap: cover property (blkWrap);
	c_m7_rx: cover property (step && rxSeed);

endmodule : odr_randomizer

/* File: odr_fec_sink.sv */
// Behavioural FEC-side bit sink that can stall and records accepted bits.
module odr_fec_sink import odr_pkg::*; (
	// Clock and reset.
	input wire logic ref_clk,
	input wire logic arst_n,
	// Bench control: when high the sink accepts only one cycle in four.
	input wire logic stall,
	// Bit stream from the randomizer.
	input wire logic bitValid,
	output logic bitReady,
	input wire odr_pkg::odr_bit_t bitData
);
	timeunit 1ns;
	timeprecision 1ps;

	// Pacing counter for the slow mode.
	logic [1:0] pace;
	// Every bit accepted since the bench last cleared it.
	odr_bit_t got[$];

	// The sink starts out not ready, so nothing is taken before reset ends.
	initial begin
		pace = 2'h0;
		bitReady = 1'b0;
	end

	// Ready moves only at the falling edge, clear of the sampling edge.
	always @(negedge ref_clk) begin
		pace = pace + 2'h1;
		bitReady = arst_n && (!stall || pace == 2'h0);
	end

	// A bit counts as delivered when valid and ready meet at a rising edge.
	always @(posedge ref_clk) begin
		if (arst_n && bitValid === 1'b1 && bitReady) begin
			got.push_back(bitData);
		end
	end

endmodule : odr_fec_sink

/* File: tb_top.sv */
// Self-checking testbench for the two-method data randomizer.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import odr_pkg::*;

	// Inputs of the design, all given a value at time zero.
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	logic cfgRx = 1'b0;
	logic allocStart = 1'b0;
	logic byteValid = 1'b0;
	logic stall = 1'b0;
	odr_method_t cfgMethod = ODR_M7;
	logic [15:0] allocBytes = 16'h0000;
	odr_byte_t byteData = 9'h000;
	// Outputs of the design and the sink.
	logic busy, byteReady, bitValid, bitReady;
	odr_bit_t bitData;
	// Counters for the verdict.
	int nFail = 0;
	int comparisons = 0;
	// Transmitted seven-stage stream, reused as receive input.
	logic txBits [0:134];

	// Clock at 25 MHz.
	always #20 ref_clk = ~ref_clk;

	odr_randomizer #(.ALLOC_W(16), .FIFO_DEPTH(16)) odr_randomizer_i (
		.ref_clk, .arst_n, .cfgMethod, .cfgRx, .allocStart, .allocBytes,
		.busy, .byteValid, .byteReady, .byteData, .bitValid, .bitReady,
		.bitData);

	odr_fec_sink odr_fec_sink_i (.ref_clk, .arst_n, .stall, .bitValid,
		.bitReady, .bitData);

	// Compares one value and reports a mismatch at once.
	task check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			nFail++;
			$display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
		end
	endtask : check

	// Prints the counts and the verdict, then ends the run.
	task summarize;
		$display("Comparisons %0d, mismatches %0d", comparisons, nFail);
		if (nFail == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : summarize

	// Fixed payload pattern; no randomness is wanted here.
	function automatic logic [7:0] pat(input int i);
		return 8'(i * 8'h3B + 8'h5C);
	endfunction : pat

	// Payload bit n in least significant first order.
	function automatic logic pbit(input int n);
		logic [7:0] b;
		b = pat(n / 8);
		return b[n % 8];
	endfunction : pbit

	// One step of the fifteen-stage generator; stage 1 is the MSB.
	function automatic logic step15(inout logic [14:0] r);
		logic s;
		s = r[1] ^ r[0];
		r = {s, r[14:1]};
		return s;
	endfunction : step15

	// Offers one byte and returns once it has been taken; valid stays up.
	task push(input logic [7:0] d, input logic l);
		byteValid = 1'b1;
		byteData = '{data: d, last: l};
		while (byteReady !== 1'b1) @(negedge ref_clk);
		@(negedge ref_clk);
	endtask : push

	// Starts an allocation; the method stays static for its whole length.
	task startAlloc(input odr_method_t m, input logic rx, input logic [15:0] n);
		cfgMethod = m;
		cfgRx = rx;
		allocBytes = n;
		allocStart = 1'b1;
		@(negedge ref_clk);
		allocStart = 1'b0;
		check("busy", busy, 1);
	endtask : startAlloc

	// Waits, bounded, until the block is idle and its output has drained.
	task waitIdle;
		int w;
		w = 0;
		while ((busy !== 1'b0 || bitValid !== 1'b0) && w < 20000) begin
			@(negedge ref_clk);
			w++;
		end
		check("idle", busy, 0);
	endtask : waitIdle

	// Compares a fifteen-stage allocation against a model seeded afresh.
	task checkM15(input int nAll, input int nPay, input logic rx);
		logic [14:0] r;
		logic [7:0] b;
		logic s;
		check("m15 count", odr_fec_sink_i.got.size(), nAll * 8);
		for (int k = 0; k < nAll; k++) begin
			if (k % 1250 == 0) r = 15'h4A80;
			b = (k < nPay) ? pat(k) : 8'hFF;
			for (int j = 7; j >= 0; j--) begin
				s = step15(r);
				check("m15 bit", odr_fec_sink_i.got[k*8+7-j].bitVal, b[j] ^ s);
			end
		end
	endtask : checkM15

	// Fills the FIFO before the burst, then transmits with a slow sink.
	task testM7Tx;
		logic s [0:134];
		int k;
		odr_fec_sink_i.got.delete();
		stall = 1'b1;
		for (k = 0; k < 16; k++) push(pat(k), k == 15);
		byteValid = 1'b0;
		check("fifo full", byteReady, 0);
		startAlloc(ODR_M7, 1'b0, 16'h0010);
		waitIdle();
		stall = 1'b0;
		check("fifo empty", byteReady, 1);
		check("m7 count", odr_fec_sink_i.got.size(), 135);
		check("first", odr_fec_sink_i.got[0].first, 1);
		check("last", odr_fec_sink_i.got[134].last, 1);
		for (k = 0; k < 135; k++) begin
			txBits[k] = odr_fec_sink_i.got[k].bitVal;
			// Zero prefix bits come out as the bare sequence.
			if (k < 7) begin
				s[k] = txBits[k];
			end else begin
				s[k] = s[k-4] ^ s[k-7];
				check("m7 tx bit", txBits[k], s[k] ^ pbit(k - 7));
			end
		end
		k = 0;
		for (int i = 0; i < 7; i++) k = k | (int'(s[i]) << i);
		check("m7 start state", k != 0, 1);
	endtask : testM7Tx

	// Feeds the transmitted stream back and expects the payload again.
	task testM7Rx;
		logic [7:0] b;
		odr_fec_sink_i.got.delete();
		startAlloc(ODR_M7, 1'b1, 16'h0011);
		for (int k = 0; k < 17; k++) begin
			// One filler bit completes the last byte.
			for (int j = 0; j < 8; j++) begin
				b[j] = (k * 8 + j < 135) ? txBits[k*8+j] : 1'b1;
			end
			push(b, k == 16);
		end
		byteValid = 1'b0;
		waitIdle();
		check("m7 rx count", odr_fec_sink_i.got.size(), 136);
		for (int k = 7; k < 135; k++) begin
			check("m7 rx bit", odr_fec_sink_i.got[k].bitVal, pbit(k - 7));
		end
	endtask : testM7Rx

	// Short payload in a long allocation, with a refused start mid-way.
	task testM15Tx;
		odr_fec_sink_i.got.delete();
		startAlloc(ODR_M15, 1'b0, 16'h04E4);
		push(pat(0), 1'b0);
		push(pat(1), 1'b1);
		byteValid = 1'b0;
		// The method stays put inside an allocation; the direction may
		// move, and a refused start must neither take it nor restart.
		cfgRx = 1'b1;
		allocStart = 1'b1;
		@(negedge ref_clk);
		allocStart = 1'b0;
		cfgRx = 1'b0;
		check("busy held", busy, 1);
		waitIdle();
		checkM15(1252, 2, 1'b0);
		check("m15 last", odr_fec_sink_i.got[10015].last, 1);
	endtask : testM15Tx

	// Receive direction restarts from the seed and adds no padding.
	task testM15Rx;
		odr_fec_sink_i.got.delete();
		startAlloc(ODR_M15, 1'b1, 16'h0003);
		for (int k = 0; k < 3; k++) push(pat(k), k == 2);
		byteValid = 1'b0;
		waitIdle();
		checkM15(3, 3, 1'b1);
	endtask : testM15Rx

	// Main sequence: reset for three cycles, then every scenario.
	initial begin
		repeat (3) @(negedge ref_clk);
		arst_n = 1'b1;
		@(negedge ref_clk);
		check("reset busy", busy, 0);
		check("reset ready", byteReady, 1);
		check("reset valid", bitValid, 0);
		testM7Tx();
		testM7Rx();
		testM15Tx();
		testM15Rx();
		summarize();
	end

	// Watchdog well beyond the roughly 12000 cycles the tests need.
	initial begin
		#2400000;
		nFail++;
		summarize();
	end

endmodule : tb_top
